// ### inc/sci_pkg.sv
package sci_pkg;

  // ************************************************************
  // timing
  // ************************************************************
  localparam int unsigned CLK_KHZ        = 50000;
  localparam int unsigned T_PD_UNIT_MS   = 5;
  localparam int unsigned T_SLEEP_MS     = 20;
  localparam int unsigned PD_UNIT_CYC    = T_PD_UNIT_MS * CLK_KHZ;
  localparam int unsigned SLEEP_CYC      = T_SLEEP_MS * CLK_KHZ;
  localparam int unsigned UNIT_W         = 18;
  localparam int unsigned INACT_W        = 20;

  // ************************************************************
  // command codes
  // ************************************************************
  localparam logic [7:0] CMD_IDLE_A      = 8'h97;
  localparam logic [7:0] CMD_IDLE_B      = 8'he3;
  localparam logic [7:0] CMD_IDLE_IMM_A  = 8'h95;
  localparam logic [7:0] CMD_IDLE_IMM_B  = 8'he1;
  localparam logic [7:0] CMD_INIT_GEOM   = 8'h91;
  localparam logic [7:0] CMD_NOP         = 8'h00;
  localparam logic [7:0] CMD_READ_BUF    = 8'he4;
  localparam logic [7:0] CMD_READ_DMA    = 8'hc8;

  // ************************************************************
  // register byte offsets
  // ************************************************************
  localparam logic [4:0] REG_CMD         = 5'h00;
  localparam logic [4:0] REG_TASK        = 5'h04;
  localparam logic [4:0] REG_DRVHEAD     = 5'h08;
  localparam logic [4:0] REG_STATUS      = 5'h0c;
  localparam logic [4:0] REG_CONFIG      = 5'h10;
  localparam logic [4:0] REG_GEOM        = 5'h14;
  localparam logic [4:0] REG_POWER       = 5'h18;
  localparam logic [4:0] REG_DATA        = 5'h1c;

  // ************************************************************
  // field positions and reset values
  // ************************************************************
  localparam int unsigned DH_DEV_BIT     = 4;
  localparam int unsigned DH_LBA_BIT     = 6;
  localparam int unsigned ST_BUSY_BIT    = 7;
  localparam int unsigned ST_READY_BIT   = 6;
  localparam int unsigned ST_DRQ_BIT     = 3;
  localparam int unsigned ST_ERR_BIT     = 0;
  localparam logic [7:0] ERR_ABORT       = 8'h04;
  localparam logic [7:0] ERR_UNCORR      = 8'h40;
  localparam logic [7:0] RST_SPT         = 8'h20;
  localparam logic [3:0] RST_HEADS_M1    = 4'h3;
  localparam logic [8:0] SECTOR_WORDS    = 9'h100;
  localparam logic [8:0] MAX_SECTORS     = 9'h100;

  // ************************************************************
  // types
  // ************************************************************
  typedef enum logic [2:0] {
    S_IDLE = 3'h0,
    S_EXEC = 3'h1,
    S_FILL = 3'h2,
    S_DMA  = 3'h3,
    S_PIO  = 3'h4
  } sci_state_t;

  // layout equals the 28-bit block address, head field on top
  typedef struct packed {
    logic [3:0] head;
    logic [7:0] cyl_hi;
    logic [7:0] cyl_lo;
    logic [7:0] snum;
  } sci_addr_t;

  typedef struct packed {
    sci_state_t       st;
    logic [7:0]       cmd;
    logic [7:0]       scnt;
    sci_addr_t        addr;
    logic             lba;
    logic             dev;
    logic [7:0]       error;
    logic             busy_flag;
    logic             data_request_flag;
    logic             err;
    logic             intrq;
    logic             eight_bit;
    logic             dev_pos;
    logic [7:0]       spt;
    logic [3:0]       heads_m1;
    logic             idle_mode;
    logic             sleep_mode;
    logic             apd_en;
    logic             idle_seen;
    logic [7:0]       pd_count;
    logic [7:0]       pd_left;
    logic [UNIT_W-1:0] unit_cnt;
    logic [INACT_W-1:0] inact_cnt;
    logic [8:0]       remain;
    logic [7:0]       wptr;
    logic [8:0]       rptr;
    logic             dma_req;
    logic [15:0]      dma_data;
    logic             media_req;
    sci_addr_t        media_addr;
    logic             media_lba;
    logic             wr_pend;
    logic [4:0]       wr_addr;
    logic [31:0]      hrdata;
    logic             hreadyout;
    logic             hresp;
    logic             ior_s1;
    logic             ior_s2;
    logic             ior_s3;
    logic             ack_s1;
    logic             ack_s2;
  } sci_regs_t;

endpackage

// ### core/sci_cmd_core.sv
// The implementer's own choices: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/10ps
// Contract
// - idle: busy, idle mode, unbusy, interrupt
// - nonzero count arms power-down timer of count x 5 ms
// - zero count disables automatic power-down
// - never idled: sleep after 20 ms quiet
// - idle immediate: busy, idle, interrupt, no params
// - init params stores sectors and heads
// - geometry from count and low head field
// - nop always aborts
// - read buffer returns buffer like sector read
// - dma read moves 1 to 256 sectors
// - count zero means 256 sectors
// - dma read starts at task file address
// - busy while filling, then drq, unbusy
// - dma request held while data buffered
// - dma read interrupts only at end/error
// - success leaves last sector address
// - error stops at failing sector address
// - eight-bit mode aborts dma read
// - lba split across head, cylinders, sector
// - single-sector protocol: drq, unbusy, interrupt
module sci_cmd_core
  import sci_pkg::*;
#(
  parameter int unsigned PD_UNIT_CYCLES = PD_UNIT_CYC,
  parameter int unsigned SLEEP_CYCLES   = SLEEP_CYC
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  output logic             host_intrq,
  output logic             dma_request_line,
  output logic      [15:0] dma_read_data,
  input  wire logic        dma_acknowledge_n,
  input  wire logic        io_read_strobe_n,
  output logic             media_rd_req,
  output sci_addr_t        media_addr,
  output logic             media_lba_mode,
  input  wire logic        media_wvalid,
  input  wire logic [15:0] media_wdata,
  input  wire logic        media_done,
  input  wire logic        media_error
);

  // ************************************************************
  // sector buffer
  // ************************************************************
  logic [15:0] sbuf [0:255];
  logic        buf_we;
  logic [15:0] buf_rd;
  sci_regs_t   r;
  sci_regs_t   n;

  assign buf_rd = sbuf[r.rptr[7:0]];

  // no reset on the array: its content is undefined until first fill
  always_ff @(posedge hclk) begin
    if (buf_we) begin
      sbuf[r.wptr] <= media_wdata;
    end
  end

  // ************************************************************
  // helpers
  // ************************************************************
  // address of the following sector, block or cylinder/head/sector form
  function automatic sci_addr_t next_addr(sci_addr_t a, logic lba,
                                          logic [7:0] spt, logic [3:0] hm1);
    sci_addr_t   b;
    logic [15:0] cyl;
    b   = a;
    cyl = {a.cyl_hi, a.cyl_lo};
    if (lba) begin
      b = sci_addr_t'(a + 28'h0000001);
    end else if (a.snum >= spt) begin
      b.snum = 8'h01;
      if (a.head >= hm1) begin
        b.head              = 4'h0;
        cyl                 = cyl + 16'h0001;
        {b.cyl_hi, b.cyl_lo} = cyl;
      end else begin
        b.head = a.head + 4'h1;
      end
    end else begin
      b.snum = a.snum + 8'h01;
    end
    return b;
  endfunction

  function automatic logic is_cmd(logic [7:0] c, logic [7:0] x, logic [7:0] y);
    return (c == x) || (c == y);
  endfunction

  // ************************************************************
  // next-state logic
  // ************************************************************
  logic       a_phase;
  logic       cmd_go;
  logic [7:0] cmd_in;
  logic [7:0] status_b;

  always_comb begin
    n       = r;
    buf_we  = 1'b0;
    cmd_go  = 1'b0;
    cmd_in  = hwdata[7:0];
    a_phase = hsel & htrans[1] & hready;
    status_b = 8'h00;
    status_b[ST_BUSY_BIT]  = r.busy_flag;
    status_b[ST_READY_BIT] = ~r.busy_flag;
    status_b[ST_DRQ_BIT]   = r.data_request_flag;
    status_b[ST_ERR_BIT]   = r.err;

    // pin synchronisers, first stage read only by the second
    n.ior_s1    = io_read_strobe_n;
    n.ior_s2    = r.ior_s1;
    n.ior_s3    = r.ior_s2;
    n.ack_s1    = dma_acknowledge_n;
    n.ack_s2    = r.ack_s1;
    n.media_req = 1'b0;
    n.hreadyout = 1'b1;
    n.hresp     = 1'b0;

    // bus write data phase; task file is frozen while a command runs
    if (r.wr_pend) begin
      unique case (r.wr_addr)
        REG_CMD: begin
          cmd_go = (r.st == S_IDLE);
        end
        REG_TASK: begin
          if (r.st == S_IDLE) begin
            n.scnt        = hwdata[7:0];
            n.addr.snum   = hwdata[15:8];
            n.addr.cyl_lo = hwdata[23:16];
            n.addr.cyl_hi = hwdata[31:24];
          end
        end
        REG_DRVHEAD: begin
          if (r.st == S_IDLE) begin
            n.addr.head = hwdata[3:0];
            n.dev       = hwdata[DH_DEV_BIT];
            n.lba       = hwdata[DH_LBA_BIT];
          end
        end
        REG_CONFIG: begin
          n.eight_bit = hwdata[0];
          n.dev_pos   = hwdata[1];
        end
        default: begin
        end
      endcase
    end

    // bus address phase; read data is captured here for a zero-wait answer
    n.wr_pend = a_phase & hwrite;
    n.wr_addr = haddr[4:0];
    if (a_phase && !hwrite) begin
      unique case (haddr[4:0])
        REG_CMD:     n.hrdata = {24'h000000, r.cmd};
        REG_TASK:    n.hrdata = {r.addr.cyl_hi, r.addr.cyl_lo, r.addr.snum, r.scnt};
        REG_DRVHEAD: n.hrdata = {24'h000000, 1'b1, r.lba, 1'b1, r.dev, r.addr.head};
        REG_STATUS: begin
          n.hrdata = {12'h000, r.dma_req, r.sleep_mode, r.idle_mode, r.intrq,
                      r.error, status_b};
          n.intrq  = 1'b0; // status read acknowledges the interrupt
        end
        REG_CONFIG:  n.hrdata = {30'h00000000, r.dev_pos, r.eight_bit};
        REG_GEOM:    n.hrdata = {20'h00000, r.heads_m1, r.spt};
        REG_POWER:   n.hrdata = {13'h0000, r.idle_seen, r.apd_en, r.sleep_mode,
                                 r.pd_left, r.pd_count};
        REG_DATA: begin
          n.hrdata = {16'h0000, buf_rd};
          if (r.st == S_PIO && r.data_request_flag && r.rptr != SECTOR_WORDS) begin
            n.rptr = r.rptr + 9'h001;
          end
        end
        default:     n.hrdata = 32'h00000000;
      endcase
    end

    // command acceptance; other device's commands are dropped silently
    if (cmd_go && (r.dev == r.dev_pos)) begin
      n.cmd        = cmd_in;
      n.err        = 1'b0;
      n.error      = 8'h00;
      n.busy_flag  = 1'b1;
      n.st         = S_EXEC;
      n.sleep_mode = 1'b0;
      n.inact_cnt  = '0;
      n.unit_cnt   = '0;
      n.pd_left    = r.pd_count;
      if (is_cmd(cmd_in, CMD_IDLE_A, CMD_IDLE_B)) begin
        n.idle_seen = 1'b1;
        if (r.scnt != 8'h00) begin
          n.apd_en   = 1'b1;
          n.pd_count = r.scnt;
          n.pd_left  = r.scnt;
        end else begin
          n.apd_en = 1'b0;
        end
      end else if (cmd_in == CMD_INIT_GEOM) begin
        n.spt      = r.scnt;
        n.heads_m1 = r.addr.head;
      end else if (cmd_in == CMD_READ_DMA && !r.eight_bit) begin
        n.remain    = (r.scnt == 8'h00) ? MAX_SECTORS : {1'b0, r.scnt};
        n.wptr      = 8'h00;
        n.rptr      = 9'h000;
        n.media_req = 1'b1;
        n.idle_mode = 1'b0;
        n.st        = S_FILL;
      end
    end

    // command execution
    unique case (r.st)
      S_IDLE: begin
      end
      S_EXEC: begin
        n.busy_flag = 1'b0;
        n.intrq     = 1'b1;
        n.st        = S_IDLE;
        if (is_cmd(r.cmd, CMD_IDLE_A, CMD_IDLE_B) ||
            is_cmd(r.cmd, CMD_IDLE_IMM_A, CMD_IDLE_IMM_B)) begin
          n.idle_mode = 1'b1;
        end else if (r.cmd == CMD_READ_BUF) begin
          n.data_request_flag = 1'b1;
          n.rptr              = 9'h000;
          n.st                = S_PIO;
        end else if (r.cmd != CMD_INIT_GEOM) begin
          // nop, dma read in eight-bit mode, and anything unknown
          n.err   = 1'b1;
          n.error = ERR_ABORT;
        end
      end
      S_FILL: begin
        if (media_wvalid) begin
          buf_we = 1'b1;
          n.wptr = r.wptr + 8'h01;
        end
        if (media_error) begin
          // address fields still name the failing sector
          n.busy_flag = 1'b0;
          n.err       = 1'b1;
          n.error     = ERR_UNCORR;
          n.intrq     = 1'b1;
          n.st        = S_IDLE;
        end else if (media_done) begin
          n.busy_flag         = 1'b0;
          n.data_request_flag = 1'b1;
          n.rptr              = 9'h000;
          n.st                = S_DMA;
        end
      end
      S_DMA: begin
        if (r.rptr == SECTOR_WORDS) begin
          n.data_request_flag = 1'b0;
          if (r.remain == 9'h001) begin
            // no address step after the last one
            n.intrq = 1'b1;
            n.st    = S_IDLE;
          end else begin
            n.remain    = r.remain - 9'h001;
            n.addr      = next_addr(r.addr, r.lba, r.spt, r.heads_m1);
            n.wptr      = 8'h00;
            n.busy_flag = 1'b1;
            n.media_req = 1'b1;
            n.st        = S_FILL;
          end
        end else if (r.ior_s2 && !r.ior_s3 && !r.ack_s2) begin
          n.rptr = r.rptr + 9'h001;
        end
      end
      S_PIO: begin
        if (r.rptr == SECTOR_WORDS) begin
          n.data_request_flag = 1'b0;
          n.st                = S_IDLE;
        end
      end
      default: begin
        n.st        = S_IDLE;
        n.busy_flag = 1'b0;
      end
    endcase

    // power timers run only while nothing is executing
    if (r.st == S_IDLE && !cmd_go && !r.sleep_mode) begin
      if (!r.idle_seen) begin
        if (r.inact_cnt == INACT_W'(SLEEP_CYCLES - 1)) begin
          n.inact_cnt  = '0;
          n.sleep_mode = 1'b1;
          n.idle_mode  = 1'b0;
        end else begin
          n.inact_cnt = r.inact_cnt + INACT_W'(1);
        end
      end else if (r.apd_en) begin
        if (r.unit_cnt == UNIT_W'(PD_UNIT_CYCLES - 1)) begin
          n.unit_cnt = '0;
          n.pd_left  = r.pd_left - 8'h01;
          if (r.pd_left == 8'h01) begin
            n.sleep_mode = 1'b1;
            n.idle_mode  = 1'b0;
          end
        end else begin
          n.unit_cnt = r.unit_cnt + UNIT_W'(1);
        end
      end
    end

    // pin-facing copies, so every output comes from a flip-flop
    n.dma_req    = (n.st == S_DMA) && (n.rptr != SECTOR_WORDS);
    n.dma_data   = sbuf[n.rptr[7:0]];
    n.media_addr = n.addr;
    n.media_lba  = n.lba;
  end

  // ************************************************************
  // state register
  // ************************************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r           <= '0;
      r.st        <= S_IDLE;
      r.spt       <= RST_SPT;
      r.heads_m1  <= RST_HEADS_M1;
      r.hreadyout <= 1'b1;
      r.ior_s1    <= 1'b1;
      r.ior_s2    <= 1'b1;
      r.ior_s3    <= 1'b1;
      r.ack_s1    <= 1'b1;
      r.ack_s2    <= 1'b1;
    end else begin
      r <= n;
    end
  end

  assign hrdata           = r.hrdata;
  assign hreadyout        = r.hreadyout;
  assign hresp            = r.hresp;
  assign host_intrq       = r.intrq;
  assign dma_request_line = r.dma_req;
  assign dma_read_data    = r.dma_data;
  assign media_rd_req     = r.media_req;
  assign media_addr       = r.media_addr;
  assign media_lba_mode   = r.media_lba;

endmodule

// ### test/sci_cmd_core_asserts.sv
`timescale 1ns/10ps
module sci_cmd_core_asserts
  import sci_pkg::*;
(
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        host_intrq,
  input wire logic        dma_request_line,
  input wire logic [15:0] dma_read_data,
  input wire logic        dma_acknowledge_n,
  input wire logic        io_read_strobe_n,
  input wire logic        media_rd_req,
  input wire logic        media_wvalid,
  input wire logic [15:0] media_wdata,
  input wire logic        media_done,
  input wire logic        media_error
);
  logic [8:0]  words_ff;
  logic [15:0] first_ff;
  logic        got_ff;
  // ****************************************
  // helpers: strobes per request span, first word filled
  // ****************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      words_ff <= 9'h000;
      first_ff <= 16'h0000;
      got_ff   <= 1'b0;
    end else begin
      if ($rose(dma_request_line))
        words_ff <= 9'h000;
      else if ($rose(io_read_strobe_n) && !dma_acknowledge_n)
        words_ff <= words_ff + 9'h001;
      // the fetch pulse re-arms capture so each sector is judged alone
      if (media_rd_req)
        got_ff <= 1'b0;
      else if (media_wvalid && !got_ff) begin
        first_ff <= media_wdata;
        got_ff   <= 1'b1;
      end
    end
  end

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  sequence s_fetch_ok;
    media_done && !media_error;
  endsequence
  sequence s_fetch_start;
    media_rd_req && !dma_request_line;
  endsequence

  property p_irq_idle_line;
    $rose(host_intrq) |-> !dma_request_line;
  endproperty
  property p_fetch_idle_line;
    media_rd_req |-> s_fetch_start;
  endproperty
  property p_done_req;
    s_fetch_ok |-> ##[1:2] dma_request_line;
  endproperty
  property p_err_irq;
    media_error |-> ##[1:3] host_intrq;
  endproperty
  property p_req_holds;
    (dma_request_line && io_read_strobe_n) [*6] |=> dma_request_line;
  endproperty
  property p_words;
    $fell(dma_request_line) |-> words_ff == 9'h100;
  endproperty
  property p_first;
    $rose(dma_request_line) |=> dma_read_data == first_ff;
  endproperty
  property p_fetch_quiet;
    media_rd_req |=> !$rose(host_intrq) [*8];
  endproperty

  a_irq_idle_line: assert property (p_irq_idle_line) else $error("irq with dma request");
  a_fetch_idle_line: assert property (p_fetch_idle_line) else $error("fetch with request");
  a_done_req: assert property (p_done_req) else $error("no dma request after fill");
  a_err_irq: assert property (p_err_irq) else $error("no irq after media error");
  a_req_holds: assert property (p_req_holds) else $error("request dropped unread");
  a_words: assert property (p_words) else $error("wrong word count per sector");
  a_first: assert property (p_first) else $error("first dma word wrong");
  a_fetch_quiet: assert property (p_fetch_quiet) else $error("irq during fetch");
endmodule

bind sci_cmd_core sci_cmd_core_asserts i_sci_cmd_core_asserts (
  .hclk(hclk), .hresetn(hresetn), .host_intrq(host_intrq),
  .dma_request_line(dma_request_line), .dma_read_data(dma_read_data),
  .dma_acknowledge_n(dma_acknowledge_n), .io_read_strobe_n(io_read_strobe_n),
  .media_rd_req(media_rd_req), .media_wvalid(media_wvalid),
  .media_wdata(media_wdata), .media_done(media_done), .media_error(media_error)
);

// ### test/sci_dma_host.sv
`timescale 1ns/10ps
module sci_dma_host (
  input  wire logic        hclk,
  input  wire logic        slow,
  input  wire logic        dma_request_line,
  input  wire logic [15:0] dma_read_data,
  output logic             dma_acknowledge_n,
  output logic             io_read_strobe_n
);
  logic [15:0] rx [$];
  // ****************************************
  // host dma engine: ack, then one strobe per word
  // ****************************************
  initial begin
    dma_acknowledge_n = 1'b1;
    io_read_strobe_n  = 1'b1;
    forever begin
      @(posedge hclk);
      if (dma_request_line === 1'b1) begin
        repeat (slow ? 10 : 3) @(posedge hclk);
        dma_acknowledge_n <= 1'b0;
        // strobe low and high each last well over the two-flop sync
        while (dma_request_line === 1'b1) begin
          io_read_strobe_n <= 1'b0;
          repeat (3) @(posedge hclk);
          rx.push_back(dma_read_data);
          io_read_strobe_n <= 1'b1;
          repeat (slow ? 7 : 5) @(posedge hclk);
        end
        dma_acknowledge_n <= 1'b1;
      end
    end
  end
endmodule

// ### test/test_storage_card_idle_dma_read_cmds.sv
`timescale 1ns/10ps
module test_storage_card_idle_dma_read_cmds;
  import sci_pkg::*;
  localparam int PD_T = 20;
  localparam int SL_T = 50;
  logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, slow = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic        hready, hreadyout, hresp, host_intrq, dma_request_line;
  logic        dma_acknowledge_n, io_read_strobe_n, media_rd_req, media_lba_mode;
  logic [15:0] dma_read_data, media_wdata = 16'h0;
  logic        media_wvalid = 1'b0, media_done = 1'b0, media_error = 1'b0;
  sci_addr_t   media_addr;
  sci_addr_t   ma [$];
  logic [7:0]  sn;
  int          fail_at = 0, n_errors = 0, n_tests = 0;
  logic [7:0]  ic [4] = '{CMD_IDLE_A, CMD_IDLE_B, CMD_IDLE_IMM_A, CMD_IDLE_IMM_B};

  assign hready = hreadyout;
  always #10 hclk = ~hclk;

  sci_cmd_core #(.PD_UNIT_CYCLES(PD_T), .SLEEP_CYCLES(SL_T)) i_sci_cmd_core (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .host_intrq(host_intrq),
    .dma_request_line(dma_request_line), .dma_read_data(dma_read_data),
    .dma_acknowledge_n(dma_acknowledge_n), .io_read_strobe_n(io_read_strobe_n),
    .media_rd_req(media_rd_req), .media_addr(media_addr), .media_lba_mode(media_lba_mode),
    .media_wvalid(media_wvalid), .media_wdata(media_wdata), .media_done(media_done),
    .media_error(media_error)
  );
  sci_dma_host i_sci_dma_host (
    .hclk(hclk), .slow(slow), .dma_request_line(dma_request_line),
    .dma_read_data(dma_read_data), .dma_acknowledge_n(dma_acknowledge_n),
    .io_read_strobe_n(io_read_strobe_n)
  );

  // ****************************************
  // media side: one sector per fetch, word = {sector, index}
  // ****************************************
  always begin
    @(posedge hclk);
    if (media_rd_req === 1'b1) begin
      ma.push_back(media_addr);
      sn = media_addr.snum;
      for (int k = 0; k < 256; k++) begin
        @(posedge hclk);
        media_wvalid <= 1'b1;
        media_wdata  <= {sn, 8'(k)};
      end
      @(posedge hclk);
      media_wvalid <= 1'b0;
      if (ma.size() == fail_at) media_error <= 1'b1;
      else media_done <= 1'b1;
      @(posedge hclk);
      media_done  <= 1'b0;
      media_error <= 1'b0;
    end
  end

  // ****************************************
  // bus, wait and compare helpers
  // ****************************************
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // every open-ended wait goes through here so a hang always ends the run
  task automatic tick(inout int k);
    @(posedge hclk);
    k++;
    if (k > 20000) begin
      n_errors++;
      give_verdict();
    end
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] e, input logic [31:0] m);
    n_tests++;
    if ((got & m) !== (e & m)) begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got & m, e & m);
    end
  endtask
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    int k = 0;
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr  <= {27'h0, a};
    do tick(k); while (hready !== 1'b1);
    htrans <= 2'h0;
    hsel   <= 1'b0;
    hwdata <= d;
    do tick(k); while (hready !== 1'b1);
    r = hrdata;
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask
  task automatic rdc(input logic [4:0] a, input logic [31:0] e, input logic [31:0] m);
    logic [31:0] r;
    bus(1'b0, a, 32'h0, r);
    chk(r, e, m);
  endtask
  task automatic cmd(input logic [7:0] c, input logic [31:0] e, input logic [31:0] m);
    int k = 0;
    wr(REG_CMD, {24'h0, c});
    while (host_intrq !== 1'b1) tick(k);
    rdc(REG_STATUS, e, m);
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic s_sleep;
    repeat (25) @(posedge hclk);
    rdc(REG_POWER, 32'h0, 32'h10000);
    repeat (40) @(posedge hclk);
    rdc(REG_POWER, 32'h10000, 32'h50000);
  endtask
  task automatic s_idle;
    foreach (ic[i]) begin
      wr(REG_TASK, (i < 2) ? 32'h0 : 32'h5);
      cmd(ic[i], 32'h30000, 32'h3ff89);
      rdc(REG_POWER, 32'h40000, 32'h70000);
    end
    wr(REG_TASK, 32'h2);
    cmd(CMD_IDLE_A, 32'h30000, 32'h3ff89);
    rdc(REG_POWER, 32'h60002, 32'h700ff);
    repeat (60) @(posedge hclk);
    rdc(REG_POWER, 32'h10000, 32'h10000);
    wr(REG_TASK, 32'h0);
    cmd(CMD_IDLE_B, 32'h30000, 32'h3ff89);
    repeat (100) @(posedge hclk);
    rdc(REG_POWER, 32'h40000, 32'h70000);
  endtask
  task automatic s_geom;
    rdc(REG_GEOM, 32'h320, 32'hfff);
    wr(REG_DRVHEAD, 32'h15);
    wr(REG_CMD, {24'h0, CMD_INIT_GEOM});
    repeat (5) @(posedge hclk);
    chk({31'h0, host_intrq}, 32'h0, 32'h1);
    rdc(REG_GEOM, 32'h320, 32'hfff);
    wr(REG_TASK, 32'hffffff11);
    wr(REG_DRVHEAD, 32'hc5);
    cmd(CMD_INIT_GEOM, 32'h10000, 32'h1ff89);
    rdc(REG_GEOM, 32'h511, 32'hfff);
  endtask
  task automatic s_abort;
    cmd(CMD_NOP, 32'h10401, 32'h1ff89);
    chk({30'h0, hresp, hreadyout}, 32'h1, 32'h3);
    wr(REG_CONFIG, 32'h1);
    cmd(CMD_READ_DMA, 32'h10401, 32'h1ff89);
    chk(32'(ma.size()), 32'h0, 32'hffffffff);
    wr(REG_CONFIG, 32'h0);
  endtask
  task automatic s_dma;
    wr(REG_TASK, 32'h3412ff02);
    wr(REG_DRVHEAD, 32'h45);
    cmd(CMD_READ_DMA, 32'h10000, 32'h1ff89);
    chk(32'(ma.size()), 32'h2, 32'hffffffff);
    chk({4'h0, ma[0]}, 32'h053412ff, 32'hffffffff);
    chk({4'h0, ma[1]}, 32'h05341300, 32'hffffffff);
    chk(32'(i_sci_dma_host.rx.size()), 32'h200, 32'hffffffff);
    chk({31'h0, media_lba_mode}, 32'h1, 32'h1);
    foreach (i_sci_dma_host.rx[i])
      chk({16'h0, i_sci_dma_host.rx[i]}, {16'h0, i < 256 ? 8'hff : 8'h00, 8'(i)}, 32'hffff);
    rdc(REG_TASK, 32'h34130000, 32'hffffff00);
    cmd(CMD_READ_BUF, 32'h10008, 32'h1ff89);
    for (int i = 0; i < 256; i++) rdc(REG_DATA, {24'h0, 8'(i)}, 32'hffff);
    rdc(REG_STATUS, 32'h0, 32'h89);
  endtask
  task automatic s_err;
    slow <= 1'b1;
    ma.delete();
    fail_at = 3;
    // cylinder/head/sector form: sector, head and cylinder all carry before the failure
    wr(REG_TASK, 32'h00ff1000);
    wr(REG_DRVHEAD, 32'h05);
    cmd(CMD_READ_DMA, 32'h14001, 32'h1ff89);
    chk(32'(ma.size()), 32'h3, 32'hffffffff);
    chk({4'h0, ma[2]}, 32'h00010001, 32'hffffffff);
    chk({31'h0, media_lba_mode}, 32'h0, 32'h1);
    rdc(REG_TASK, 32'h01000100, 32'hffffff00);
    rdc(REG_DRVHEAD, 32'ha0, 32'hff);
  endtask

  initial begin
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    s_sleep();
    s_idle();
    s_geom();
    s_abort();
    s_dma();
    s_err();
    give_verdict();
  end
endmodule
